// ---- design/acr_pkg.sv ----
// package: register map, field positions, timing and carriers for the converter control bank
package acr_pkg;

   // ----------------------------------------------------------------
   // register addresses (processor byte addresses)
   // ----------------------------------------------------------------
   localparam logic [31:0] ACR_ADDR_TEMP_CFG   = 32'h4000_0527;
   localparam logic [31:0] ACR_ADDR_SHARED_CFG = 32'h4000_0529;
   localparam logic [31:0] ACR_ADDR_CODE_A_LO  = 32'h4000_0530;
   localparam logic [31:0] ACR_ADDR_CODE_A_HI  = 32'h4000_0531;
   localparam logic [31:0] ACR_ADDR_CODE_B_LO  = 32'h4000_0532;
   localparam logic [31:0] ACR_ADDR_CODE_B_HI  = 32'h4000_0533;
   localparam logic [31:0] ACR_ADDR_DRIVE_CTRL = 32'h4000_0538;
   localparam logic [31:0] ACR_ADDR_REF_MODE   = 32'h4000_0539;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ACR_TC_ON_BIT      = 0;  // temp_decimator_on
   localparam int ACR_TC_WIDE_BIT    = 1;  // temp_wide_result
   localparam int ACR_TC_PERIOD_BIT  = 2;  // temp_sample_period_sel
   localparam int ACR_TC_IRQDIV_BIT  = 3;  // temp_irq_divider
   localparam int ACR_SC_MODHOLD_BIT = 0;  // modulator_hold
   localparam int ACR_SC_CLKHOLD_BIT = 1;  // modulator clock hold
   localparam int ACR_SC_CONVEN_BIT  = 4;  // converter interface enable
   localparam int ACR_DC_DRIVE_BIT   = 0;  // drive from code a
   localparam int ACR_DC_SPARE_BIT   = 1;  // plain read/write bit
   localparam int ACR_DC_SELB_BIT    = 4;  // status: code b selected
   localparam int ACR_DC_RUN_BIT     = 5;  // status: decimator running
   localparam int ACR_RM_RATIO_BIT   = 0;  // ratiometric mode

   // ----------------------------------------------------------------
   // writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ACR_TEMP_CFG_MASK   = 8'h0F;
   localparam logic [7:0] ACR_SHARED_CFG_MASK = 8'h7F;
   localparam logic [7:0] ACR_DRIVE_CTRL_MASK = 8'h03;
   localparam logic [7:0] ACR_REF_MODE_MASK   = 8'h01;
   localparam logic [7:0] ACR_TEMP_CFG_RST    = 8'h00;
   localparam logic [7:0] ACR_SHARED_CFG_RST  = 8'h03;
   localparam logic [7:0] ACR_CODE_RST        = 8'h00;
   localparam logic [7:0] ACR_DRIVE_CTRL_RST  = 8'h00;
   localparam logic [7:0] ACR_REF_MODE_RST    = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int ACR_CLK_HZ         = 20_000_000;
   localparam int ACR_PERIOD_SHORT_US = 64;
   localparam int ACR_PERIOD_LONG_US  = 128;
   localparam int ACR_CYC_SHORT = ACR_PERIOD_SHORT_US * (ACR_CLK_HZ / 1_000_000);
   localparam int ACR_CYC_LONG  = ACR_PERIOD_LONG_US * (ACR_CLK_HZ / 1_000_000);
   localparam int ACR_IRQ_EVERY_N    = 4;
   localparam int ACR_WIDE_BITS      = 24;
   localparam int ACR_NARROW_BITS    = 16;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        wr;     // write strobe
      logic        rd;     // read strobe
      logic [31:0] addr;   // byte address
      logic [7:0]  wdata;  // write data
   } acr_req_s;

   typedef struct packed {
      logic        modulator_hold;  // both modulators in reset
      logic        mod_clk_hold;    // modulator clocks in reset
      logic        conv_if_on;      // interfaces and decimator clocks on
   } acr_conv_ctl_s;

   typedef struct packed {
      logic [15:0] code;         // code presented to the dac
      logic        code_b_sel;   // code b in use
      logic        gain_direct;  // gain stage takes code a
      logic        gain_pwm;     // gain stage follows pwm setting
      logic        ratiometric;  // 1 ratiometric, 0 absolute
   } acr_dac_ctl_s;

endpackage : acr_pkg

// ---- design/acr_regs.sv ----
// converter control register bank with temperature decimator pacing and dac code selection
`timescale 1ns/1ps

// Functional notes
// [RULE1] temperature decimator runs only while its config bit 0 is set
// [RULE2] decimator result width is 24 bits when width bit set, else 16
// [RULE3] sample every 128 us when rate bit set, else every 64 us
// [RULE4] interrupt every fourth sample when bit 3 set, else every sample
// [RULE5] both modulators held in reset while bit 0 is 1; resets to 1
// [RULE6] modulator clocks held in reset while bit 1 is 1; resets to 1
// [RULE7] converter interfaces and decimator clocks enabled only while bit 4 is 1
// [RULE8] software writes zero to reserved bits 2, 3, 5 and 6
// [RULE9] pwm disabled: dac always driven from code a
// [RULE10] pwm enabled: code a while pwm level 0, code b while 1; the code keeps code a whenever the drive bit is 1
// [RULE11] drive bit 1 gives gain stage code a; 0 follows pwm enable
// [RULE12] dac ratiometric when mode bit 1, absolute when 0; resets 0
module acr_regs #(
   parameter int CYC_SHORT = acr_pkg::ACR_CYC_SHORT, // 64 us in clocks
   parameter int CYC_LONG  = acr_pkg::ACR_CYC_LONG   // 128 us in clocks
) (
   input  wire logic                   clk,            // 20 MHz system clock
   input  wire logic                   rstn,           // synchronous reset, active low
   input  wire logic                   ce,             // clock enable, freezes all state
   input  wire acr_pkg::acr_req_s      req,            // register access request
   output      logic [7:0]             rdata,          // read data, registered
   output      logic                   rvalid,         // read data valid pulse
   input  wire logic                   pwm_enable,     // pwm output enabled
   input  wire logic                   pwm_level,      // current pwm output level
   output      logic                   temp_run,       // decimator running
   output      logic                   temp_wide,      // 24-bit results selected
   output      logic [4:0]             temp_width,     // result width in bits
   output      logic                   temp_sample,    // one pulse per completed sample
   output      logic                   temp_irq,       // interrupt pulse
   output      acr_pkg::acr_conv_ctl_s conv_ctl,       // shared converter controls
   output      acr_pkg::acr_dac_ctl_s  dac_ctl         // dac code and mode
);
   import acr_pkg::*;

   localparam int CW = $clog2(CYC_LONG + 1);

   logic [7:0]    temp_cfg_reg,   temp_cfg_next;
   logic [7:0]    shared_cfg_reg, shared_cfg_next;
   logic [7:0]    code_a_lo_reg,  code_a_lo_next;
   logic [7:0]    code_a_hi_reg,  code_a_hi_next;
   logic [7:0]    code_b_lo_reg,  code_b_lo_next;
   logic [7:0]    code_b_hi_reg,  code_b_hi_next;
   logic [7:0]    drive_ctl_reg,  drive_ctl_next;
   logic [7:0]    ref_mode_reg,   ref_mode_next;
   logic [7:0]    rdata_reg,      rdata_next;
   logic          rvalid_reg,     rvalid_next;
   logic [CW-1:0] tick_reg,       tick_next;
   logic [1:0]    samp_cnt_reg,   samp_cnt_next;
   logic          sample_reg,     sample_next;
   logic          irq_reg,        irq_next;
   acr_dac_ctl_s  dac_reg,        dac_next;
   logic          run;
   logic [CW-1:0] period_m1;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------

   // reserved bits are masked off except shared cfg bits 2, 3, 5 and 6, which are stored; software is expected to write 0 there
   always_comb begin
      temp_cfg_next   = temp_cfg_reg;
      shared_cfg_next = shared_cfg_reg;
      code_a_lo_next  = code_a_lo_reg;
      code_a_hi_next  = code_a_hi_reg;
      code_b_lo_next  = code_b_lo_reg;
      code_b_hi_next  = code_b_hi_reg;
      drive_ctl_next  = drive_ctl_reg;
      ref_mode_next   = ref_mode_reg;
      if (req.wr) begin
         unique case (req.addr)
            ACR_ADDR_TEMP_CFG:   temp_cfg_next   = req.wdata & ACR_TEMP_CFG_MASK;
            ACR_ADDR_SHARED_CFG: shared_cfg_next = req.wdata & ACR_SHARED_CFG_MASK; // [RULE8]
            ACR_ADDR_CODE_A_LO:  code_a_lo_next  = req.wdata;
            ACR_ADDR_CODE_A_HI:  code_a_hi_next  = req.wdata;
            ACR_ADDR_CODE_B_LO:  code_b_lo_next  = req.wdata;
            ACR_ADDR_CODE_B_HI:  code_b_hi_next  = req.wdata;
            ACR_ADDR_DRIVE_CTRL: drive_ctl_next  = req.wdata & ACR_DRIVE_CTRL_MASK;
            ACR_ADDR_REF_MODE:   ref_mode_next   = req.wdata & ACR_REF_MODE_MASK;
            default: ;  // unmapped writes are dropped
         endcase
      end
   end

   // control registers, reset values put both modulator holds on
   always_ff @(posedge clk) begin
      if (!rstn) begin
         temp_cfg_reg   <= ACR_TEMP_CFG_RST;
         shared_cfg_reg <= ACR_SHARED_CFG_RST;  // [RULE5] [RULE6]
         code_a_lo_reg  <= ACR_CODE_RST;
         code_a_hi_reg  <= ACR_CODE_RST;
         code_b_lo_reg  <= ACR_CODE_RST;
         code_b_hi_reg  <= ACR_CODE_RST;
         drive_ctl_reg  <= ACR_DRIVE_CTRL_RST;
         ref_mode_reg   <= ACR_REF_MODE_RST;    // [RULE12]
      end else if (ce) begin
         temp_cfg_reg   <= temp_cfg_next;
         shared_cfg_reg <= shared_cfg_next;
         code_a_lo_reg  <= code_a_lo_next;
         code_a_hi_reg  <= code_a_hi_next;
         code_b_lo_reg  <= code_b_lo_next;
         code_b_hi_reg  <= code_b_hi_next;
         drive_ctl_reg  <= drive_ctl_next;
         ref_mode_reg   <= ref_mode_next;
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------

   // one-cycle read answer; unmapped addresses read as zero
   always_comb begin
      rdata_next  = rdata_reg;
      rvalid_next = req.rd;
      if (req.rd) begin
         unique case (req.addr)
            ACR_ADDR_TEMP_CFG:   rdata_next = temp_cfg_reg;
            ACR_ADDR_SHARED_CFG: rdata_next = shared_cfg_reg;
            ACR_ADDR_CODE_A_LO:  rdata_next = code_a_lo_reg;
            ACR_ADDR_CODE_A_HI:  rdata_next = code_a_hi_reg;
            ACR_ADDR_CODE_B_LO:  rdata_next = code_b_lo_reg;
            ACR_ADDR_CODE_B_HI:  rdata_next = code_b_hi_reg;
            ACR_ADDR_DRIVE_CTRL: begin
               rdata_next                   = drive_ctl_reg;
               rdata_next[ACR_DC_SELB_BIT]  = dac_reg.code_b_sel;  // live status
               rdata_next[ACR_DC_RUN_BIT]   = run;
            end
            ACR_ADDR_REF_MODE:   rdata_next = ref_mode_reg;
            default:             rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ----------------------------------------------------------------
   // temperature decimator pacing
   // ----------------------------------------------------------------

   // decimator needs its own enable, interface clocks on and modulators released
   assign run = temp_cfg_reg[ACR_TC_ON_BIT]                    // [RULE1]
              & shared_cfg_reg[ACR_SC_CONVEN_BIT]              // [RULE7]
              & ~shared_cfg_reg[ACR_SC_MODHOLD_BIT]            // [RULE5]
              & ~shared_cfg_reg[ACR_SC_CLKHOLD_BIT];           // [RULE6]

   // sample period chosen by the rate bit
   assign period_m1 = temp_cfg_reg[ACR_TC_PERIOD_BIT] ?        // [RULE3]
                      CW'(CYC_LONG - 1) : CW'(CYC_SHORT - 1);

   // tick counter, sample pulse and interrupt divider
   always_comb begin
      tick_next     = tick_reg;
      samp_cnt_next = samp_cnt_reg;
      sample_next   = 1'b0;
      irq_next      = 1'b0;
      if (!run) begin
         tick_next     = '0;                                   // [RULE1]
         samp_cnt_next = '0;
      end else if (tick_reg >= period_m1) begin
         tick_next   = '0;
         sample_next = 1'b1;                                   // [RULE3]
         if (temp_cfg_reg[ACR_TC_IRQDIV_BIT]) begin
            samp_cnt_next = samp_cnt_reg + 2'd1;
            irq_next      = (samp_cnt_reg == 2'(ACR_IRQ_EVERY_N - 1)); // [RULE4]
         end else begin
            samp_cnt_next = '0;
            irq_next      = 1'b1;                              // [RULE4]
         end
      end else begin
         tick_next = tick_reg + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tick_reg     <= '0;
         samp_cnt_reg <= '0;
         sample_reg   <= 1'b0;
         irq_reg      <= 1'b0;
      end else if (ce) begin
         tick_reg     <= tick_next;
         samp_cnt_reg <= samp_cnt_next;
         sample_reg   <= sample_next;
         irq_reg      <= irq_next;
      end
   end

   // ----------------------------------------------------------------
   // dac code selection
   // ----------------------------------------------------------------

   // code b only when pwm is on, its level is high and direct drive is off
   always_comb begin
      dac_next             = dac_reg;
      dac_next.gain_direct = drive_ctl_reg[ACR_DC_DRIVE_BIT];           // [RULE11]
      dac_next.gain_pwm    = ~drive_ctl_reg[ACR_DC_DRIVE_BIT] & pwm_enable; // [RULE11]
      dac_next.code_b_sel  = ~drive_ctl_reg[ACR_DC_DRIVE_BIT]
                           & pwm_enable & pwm_level;                    // [RULE10]
      dac_next.ratiometric = ref_mode_reg[ACR_RM_RATIO_BIT];            // [RULE12]
      if (dac_next.code_b_sel) begin
         dac_next.code = {code_b_hi_reg, code_b_lo_reg};                // [RULE10]
      end else begin
         dac_next.code = {code_a_hi_reg, code_a_lo_reg};                // [RULE9]
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         dac_reg <= '0;
      end else if (ce) begin
         dac_reg <= dac_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata       = rdata_reg;
   assign rvalid      = rvalid_reg;
   assign temp_run    = run;
   assign temp_wide   = temp_cfg_reg[ACR_TC_WIDE_BIT];                  // [RULE2]
   assign temp_width  = temp_cfg_reg[ACR_TC_WIDE_BIT] ?                 // [RULE2]
                        5'(ACR_WIDE_BITS) : 5'(ACR_NARROW_BITS);
   assign temp_sample = sample_reg;
   assign temp_irq    = irq_reg;
   assign conv_ctl.modulator_hold = shared_cfg_reg[ACR_SC_MODHOLD_BIT]; // [RULE5]
   assign conv_ctl.mod_clk_hold   = shared_cfg_reg[ACR_SC_CLKHOLD_BIT]; // [RULE6]
   assign conv_ctl.conv_if_on     = shared_cfg_reg[ACR_SC_CONVEN_BIT];  // [RULE7]
   assign dac_ctl     = dac_reg;

endmodule : acr_regs

// ---- tb/acr_checker.sv ----
// checker: timing and field relations at the ports of the converter control bank
`timescale 1ns/1ps
module acr_checker import acr_pkg::*; #(
   parameter int CYC_SHORT = 8,  // short sample period in clocks
   parameter int CYC_LONG  = 16  // long sample period in clocks
) (
   input wire logic          clk,          // system clock
   input wire logic          rstn,         // synchronous reset, active low
   input wire logic          ce,           // clock enable
   input wire acr_req_s      req,          // register request
   input wire logic [7:0]    rdata,        // read data
   input wire logic          rvalid,       // read data valid
   input wire logic          pwm_enable,   // pwm enabled
   input wire logic          pwm_level,    // pwm level
   input wire logic          temp_run,     // decimator running
   input wire logic          temp_wide,    // wide results
   input wire logic [4:0]    temp_width,   // result width
   input wire logic          temp_sample,  // sample pulse
   input wire logic          temp_irq,     // interrupt pulse
   input wire acr_conv_ctl_s conv_ctl,     // converter controls
   input wire acr_dac_ctl_s  dac_ctl       // dac controls
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // cycles since the last sample pulse, saturating
   // ----------------------------------------------------------------
   // wide enough to hold a full-length period at the default clock
   logic [15:0] gap_reg;
   logic [15:0] gap_next;
   always_comb begin
      gap_next = gap_reg;
      if (temp_sample)
         gap_next = 16'h0000;
      else if (gap_reg != 16'hFFFF)
         gap_next = gap_reg + 16'h0001;
   end
   always_ff @(posedge clk) begin
      if (!rstn)
         gap_reg <= 16'hFFFF;
      else if (ce)
         gap_reg <= gap_next;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   run_off_a: assert property (!temp_run [*2] |-> !temp_sample)
      else $error("sample while decimator stopped");
   width_sel_a: assert property (temp_width == (temp_wide ? 5'h18 : 5'h10))
      else $error("result width wrong");
   sample_gap_a: assert property (temp_sample |-> gap_reg >= CYC_SHORT - 1)
      else $error("samples too close");
   irq_pace_a: assert property (temp_irq |-> temp_sample)
      else $error("interrupt without sample");
   hold_reset_a: assert property ($rose(rstn) |-> conv_ctl[2:1] == 2'h3)
      else $error("modulator holds not set after reset");
   run_gate_a: assert property (temp_run |-> conv_ctl == 3'h1)
      else $error("run without converter enable");
   pwm_off_a: assert property (!pwm_enable |=> !dac_ctl.code_b_sel)
      else $error("code b used with pwm off");
   pwm_low_a: assert property (pwm_enable && !pwm_level |=> !dac_ctl.code_b_sel)
      else $error("code b used at pwm level 0");
   gain_direct_a: assert property (dac_ctl.gain_direct |-> !dac_ctl.code_b_sel)
      else $error("direct drive not on code a");
   ratio_reset_a: assert property ($rose(rstn) |-> !dac_ctl.ratiometric)
      else $error("mode not absolute after reset");
   read_answer_a: assert property (req.rd && ce |=> rvalid)
      else $error("read not answered");
endmodule : acr_checker

// ---- tb/tb_top.sv ----
// testbench: register access, decimator pacing and dac code selection of the control bank
`timescale 1ns/1ps
module tb_top;
   import acr_pkg::*;
   localparam int CYC_S = 8;   // shortened 64 us period
   localparam int CYC_L = 16;  // shortened 128 us period
   logic          clk, rstn, ce, rvalid, pwm_enable, pwm_level;
   logic          temp_run, temp_wide, temp_sample, temp_irq;
   logic [7:0]    rdata;
   logic [4:0]    temp_width;
   acr_req_s      req;
   acr_conv_ctl_s conv_ctl;
   acr_dac_ctl_s  dac_ctl;
   int            miscompares, n_checks, ns, ni, es;
   logic [7:0]    cfgs [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h0D};

   acr_regs #(.CYC_SHORT(CYC_S), .CYC_LONG(CYC_L)) u_acr_regs (
      .clk(clk), .rstn(rstn), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
      .pwm_enable(pwm_enable), .pwm_level(pwm_level), .temp_run(temp_run),
      .temp_wide(temp_wide), .temp_width(temp_width), .temp_sample(temp_sample),
      .temp_irq(temp_irq), .conv_ctl(conv_ctl), .dac_ctl(dac_ctl));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // compare, verdict, bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd_expect(input logic [31:0] a, input logic [7:0] exp);
      int i;
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      for (i = 0; i < 4 && rvalid !== 1'b1; i++)
         @(negedge clk);
      if (i == 4) begin
         miscompares++;
         conclude();
      end else begin
         check(rdata, exp);
      end
   endtask : rd_expect
   // counts sample and interrupt pulses over n cycles
   task automatic count(input int n);
      ns = 0;
      ni = 0;
      repeat (n) begin
         @(negedge clk);
         ns += (temp_sample === 1'b1);
         ni += (temp_irq === 1'b1);
      end
   endtask : count

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      pwm_enable = 1'b0;
      pwm_level = 1'b0;
      req = '0;
      miscompares = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd_expect(ACR_ADDR_SHARED_CFG, 8'h03);
      rd_expect(ACR_ADDR_TEMP_CFG, 8'h00);
      rd_expect(ACR_ADDR_REF_MODE, 8'h00);
      rd_expect(32'h4000_0528, 8'h00);
      check(conv_ctl, 3'h6);
      // decimator on but modulators held: no samples
      wr(ACR_ADDR_TEMP_CFG, 8'h01);
      count(64);
      check(ns, 0);
      wr(ACR_ADDR_SHARED_CFG, 8'h10);
      rd_expect(ACR_ADDR_SHARED_CFG, 8'h10);
      check(conv_ctl, 3'h1);
      // every width, period and interrupt setting
      foreach (cfgs[k]) begin
         wr(ACR_ADDR_TEMP_CFG, 8'h00);
         wr(ACR_ADDR_TEMP_CFG, cfgs[k]);
         // run rises at cycle 0; samples fall at cycles N, 2N .. 64
         count(65);
         es = 64 / (cfgs[k][2] ? CYC_L : CYC_S);
         check(ns, es);
         check(ni, es / (cfgs[k][3] ? ACR_IRQ_EVERY_N : 1));
         check(temp_width, cfgs[k][1] ? ACR_WIDE_BITS : ACR_NARROW_BITS);
         check(temp_wide, cfgs[k][1]);
         check(temp_run, 1'b1);
      end
      // clock enable low freezes pacing and blocks writes
      @(posedge clk);
      ce <= 1'b0;
      wr(ACR_ADDR_REF_MODE, 8'h01);
      count(64);
      check(ns, 0);
      check(ni, 0);
      @(posedge clk);
      ce <= 1'b1;
      rd_expect(ACR_ADDR_REF_MODE, 8'h00);
      wr(ACR_ADDR_TEMP_CFG, 8'h00);
      count(64);
      check(ns, 0);
      wr(ACR_ADDR_TEMP_CFG, 8'h01);
      wr(ACR_ADDR_SHARED_CFG, 8'h00);
      count(64);
      check(ns, 0);
      // dac code selection over drive bit and pwm inputs
      wr(ACR_ADDR_CODE_A_LO, 8'h34);
      wr(ACR_ADDR_CODE_A_HI, 8'h12);
      wr(ACR_ADDR_CODE_B_LO, 8'h78);
      wr(ACR_ADDR_CODE_B_HI, 8'h56);
      rd_expect(ACR_ADDR_CODE_B_HI, 8'h56);
      for (int k = 0; k < 8; k++) begin
         wr(ACR_ADDR_DRIVE_CTRL, {7'h00, k[2]});
         pwm_enable <= k[1];
         pwm_level <= k[0];
         repeat (2) @(posedge clk);
         @(negedge clk);
         check(dac_ctl.code, (!k[2] && k[1] && k[0]) ? 16'h5678 : 16'h1234);
         check(dac_ctl.gain_direct, k[2]);
         check(dac_ctl.gain_pwm, !k[2] && k[1]);
         check(dac_ctl.code_b_sel, !k[2] && k[1] && k[0]);
         rd_expect(ACR_ADDR_DRIVE_CTRL, {3'h0, !k[2] && k[1] && k[0], 3'h0, k[2]});
      end
      wr(ACR_ADDR_REF_MODE, 8'h01);
      rd_expect(ACR_ADDR_REF_MODE, 8'h01);
      check(dac_ctl.ratiometric, 1'b1);
      wr(ACR_ADDR_REF_MODE, 8'h00);
      rd_expect(ACR_ADDR_REF_MODE, 8'h00);
      check(dac_ctl.ratiometric, 1'b0);
      conclude();
   end
endmodule : tb_top

bind acr_regs acr_checker #(.CYC_SHORT(CYC_SHORT), .CYC_LONG(CYC_LONG)) u_acr_checker (
   .clk(clk), .rstn(rstn), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
   .pwm_enable(pwm_enable), .pwm_level(pwm_level), .temp_run(temp_run),
   .temp_wide(temp_wide), .temp_width(temp_width), .temp_sample(temp_sample),
   .temp_irq(temp_irq), .conv_ctl(conv_ctl), .dac_ctl(dac_ctl));
